// ### rtl/gdi_pkg.sv
// Package for the instrument-side GPIB device interface
package gdi_pkg;

  // Bus address range and fixed widths
  localparam logic [4:0] GDI_ADDR_MAX      = 5'h1E;
  localparam logic [4:0] GDI_ADDR_RST      = 5'h00;
  localparam int         GDI_FIFO_W        = 8;
  localparam int         GDI_FIFO_D        = 8;

  // Interface message groups (low seven bits, attention asserted)
  localparam logic [1:0] GDI_GRP_CMD       = 2'h0;
  localparam logic [1:0] GDI_GRP_LISTEN    = 2'h1;
  localparam logic [1:0] GDI_GRP_TALK      = 2'h2;
  localparam logic [1:0] GDI_GRP_SECOND    = 2'h3;
  localparam logic [4:0] GDI_ADDR_UNIV     = 5'h1F;

  // Universal and addressed commands
  localparam logic [6:0] GDI_CMD_GTL       = 7'h01;
  localparam logic [6:0] GDI_CMD_SDC       = 7'h04;
  localparam logic [6:0] GDI_CMD_GET       = 7'h08;
  localparam logic [6:0] GDI_CMD_LLO       = 7'h11;
  localparam logic [6:0] GDI_CMD_DCL       = 7'h14;
  localparam logic [6:0] GDI_CMD_SPE       = 7'h18;
  localparam logic [6:0] GDI_CMD_SPD       = 7'h19;

  // Serial poll status bit holding the service request
  localparam int         GDI_RQS_BIT       = 6;

  // Acceptor handshake states
  typedef enum logic [1:0] {
    GDI_AH_IDLE = 2'b00,
    GDI_AH_WAIT = 2'b01,
    GDI_AH_HOLD = 2'b10
  } gdi_ah_e;

  // Source handshake states
  typedef enum logic [1:0] {
    GDI_SH_IDLE = 2'b00,
    GDI_SH_WAIT = 2'b01,
    GDI_SH_DRIV = 2'b10,
    GDI_SH_DONE = 2'b11
  } gdi_sh_e;

  // Data byte with end marker, carried through the buffers
  typedef struct packed {
    logic       eoi;
    logic [7:0] data;
  } gdi_byte_s;

  // Addressing and remote state shown to the instrument
  typedef struct packed {
    logic talker;
    logic listener;
    logic remote;
    logic lockout;
    logic spoll;
  } gdi_state_s;

endpackage

// ### rtl/gdi_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
`default_nettype none
module gdi_fifo
  import gdi_pkg::*;
#(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock, reset and flush
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_reg [D];
  logic [W-1:0]  mem_next [D];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and storage update; flush drops everything held
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end else begin
      if (push) begin
        mem_next[wr_reg] = in_data;
        wr_next = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_next = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule
`default_nettype wire

// ### rtl/gdi_addr_dec.sv
// Decoder of one interface message byte against the own address
`timescale 1ns/100ps
`default_nettype none
module gdi_addr_dec
  import gdi_pkg::*;
(
  // Byte and own address
  input  wire logic [7:0] dio,
  input  wire logic [4:0] my_addr,
  // Decoded messages
  output logic            is_mla,
  output logic            is_mta,
  output logic            is_ota,
  output logic            is_unl,
  output logic            is_unt,
  output logic            is_cmd,
  output logic [6:0]      cmd
);
  logic [1:0] grp;
  logic [4:0] adr;
  logic       addr_ok;

  // Parity bit is ignored; group sits in bits 6:5
  assign grp     = dio[6:5];
  assign adr     = dio[4:0];
  assign addr_ok = (my_addr <= GDI_ADDR_MAX);
  assign is_mla  = (grp == GDI_GRP_LISTEN) && (adr == my_addr) && addr_ok;
  assign is_mta  = (grp == GDI_GRP_TALK) && (adr == my_addr) && addr_ok;
  assign is_unl  = (grp == GDI_GRP_LISTEN) && (adr == GDI_ADDR_UNIV);
  assign is_unt  = (grp == GDI_GRP_TALK) && (adr == GDI_ADDR_UNIV);
  assign is_ota  = (grp == GDI_GRP_TALK) && (adr != GDI_ADDR_UNIV)
                   && !is_mta;
  assign is_cmd  = (grp == GDI_GRP_CMD);
  assign cmd     = dio[6:0];
endmodule
`default_nettype wire

// ### rtl/gdi_device_if.sv
// Instrument-side GPIB interface: handshakes, addressing, clears
`timescale 1ns/100ps
`default_nettype none
// How it works
// - The device answers only address bytes that match its own 0..30.
// - With attention asserted, bytes are decoded as interface messages.
// - With attention released, bytes go to the command path or come out.
// - Talker ends on clear, other talk address, own listen, or untalk.
// - Listener ends on clear, own talk address, or unlisten.
// - Local lockout locks the front panel; go-to-local returns local.
// - Either device clear flushes both buffers and resets the parser.
// - Either device clear aborts a running digitize acquisition.
// - Interface clear stops all activity, unaddresses, ends serial poll.
// - Full source and acceptor handshakes, basic talker, basic listener.
// - Service request, remote/local, clear, trigger, serial poll; no parallel poll, no control.
module gdi_device_if
  import gdi_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Own primary address
  input  wire logic [4:0]  my_addr,
  // GPIB management lines (true = asserted)
  input  wire logic        atn,
  input  wire logic        ifc,
  input  wire logic        ren,
  // GPIB data lines, three-signal form
  input  wire logic [7:0]  dio_in,
  output logic [7:0]       dio_out,
  output logic             dio_oe,
  input  wire logic        eoi_in,
  output logic             eoi_out,
  output logic             eoi_oe,
  // GPIB handshake lines, three-signal form; service request as output and enable only
  input  wire logic        dav_in,
  output logic             dav_out,
  output logic             dav_oe,
  input  wire logic        nrfd_in,
  output logic             nrfd_out,
  output logic             nrfd_oe,
  input  wire logic        ndac_in,
  output logic             ndac_out,
  output logic             ndac_oe,
  output logic             srq_out,
  output logic             srq_oe,
  // Received data towards the command parser
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output gdi_byte_s        rx_byte,
  // Response data from the instrument
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire gdi_byte_s   tx_byte,
  // Instrument status and events
  input  wire logic        service_req,
  input  wire logic [7:0]  stb,
  input  wire logic        acq_busy,
  output gdi_state_s       state,
  output logic             parser_reset,
  output logic             acq_abort,
  output logic             trigger
);
  gdi_ah_e    ah_reg, ah_next;
  gdi_sh_e    sh_reg, sh_next;
  gdi_state_s st_reg, st_next;
  gdi_byte_s  out_reg, out_next;
  logic       clr_reg, clr_next;
  logic       abort_reg, abort_next;
  logic       trig_reg, trig_next;
  logic       is_mla, is_mta, is_ota, is_unl, is_unt, is_cmd;
  logic [6:0] cmd;
  logic       accept, cmd_take, data_take, dev_clear;
  gdi_byte_s  rx_in, tx_q;
  logic       rx_in_ready, tx_q_valid, tx_q_ready, talk_active;

  // Message decode of the byte on the bus
  gdi_addr_dec u_dec (
    .dio     (dio_in),
    .my_addr (my_addr),
    .is_mla  (is_mla),
    .is_mta  (is_mta),
    .is_ota  (is_ota),
    .is_unl  (is_unl),
    .is_unt  (is_unt),
    .is_cmd  (is_cmd),
    .cmd     (cmd)
  );

  // Accepted byte moments: commands under attention, data when listening
  assign accept    = (ah_reg == GDI_AH_WAIT) && dav_in;
  assign cmd_take  = accept && atn;
  assign data_take = accept && !atn && st_reg.listener;
  // A selected clear meant for another listener must not flush ours
  assign dev_clear = cmd_take && is_cmd && ((cmd == GDI_CMD_DCL)
                     || (cmd == GDI_CMD_SDC && st_reg.listener));
  assign rx_in     = '{eoi: eoi_in, data: dio_in};
  // Attention or interface clear takes the bus from the talker at once
  assign talk_active = st_reg.talker && !atn && !ifc;

  // Received bytes wait here; a full buffer holds off the acceptor
  gdi_fifo #(.W($bits(gdi_byte_s)), .D(GDI_FIFO_D)) u_rx_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (dev_clear || ifc),
    .in_valid  (data_take),
    .in_ready  (rx_in_ready),
    .in_data   (rx_in),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_byte)
  );

  // Response bytes queue here until the talker sources them
  gdi_fifo #(.W($bits(gdi_byte_s)), .D(GDI_FIFO_D)) u_tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (dev_clear || ifc),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_byte),
    .out_valid (tx_q_valid),
    .out_ready (tx_q_ready),
    .out_data  (tx_q)
  );

  // Acceptor handshake: ready, take on data valid, release on its drop
  always_comb begin
    ah_next = ah_reg;
    case (ah_reg)
      GDI_AH_IDLE: begin
        // A full receive buffer keeps not-ready asserted, nothing is lost
        if ((atn || st_reg.listener) && rx_in_ready) begin
          ah_next = GDI_AH_WAIT;
        end
      end
      GDI_AH_WAIT: begin
        // Attention released while unaddressed: step out of the handshake
        if (dav_in) begin
          ah_next = GDI_AH_HOLD;
        end else if (!atn && !st_reg.listener) begin
          ah_next = GDI_AH_IDLE;
        end
      end
      GDI_AH_HOLD: begin
        if (!dav_in) begin
          ah_next = GDI_AH_IDLE;
        end
      end
      default: ah_next = GDI_AH_IDLE;
    endcase
    if (ifc) begin
      ah_next = GDI_AH_IDLE;
    end
  end

  // Source handshake: put byte, wait for ready, assert valid, wait accept
  always_comb begin
    sh_next    = sh_reg;
    out_next   = out_reg;
    tx_q_ready = 1'b0;
    case (sh_reg)
      GDI_SH_IDLE: begin
        // In serial poll the status byte goes out; the queue is left alone
        if (talk_active && (st_reg.spoll || tx_q_valid)) begin
          if (!st_reg.spoll) begin
            out_next   = tx_q;
            tx_q_ready = 1'b1;
          end
          sh_next    = GDI_SH_WAIT;
        end
      end
      GDI_SH_WAIT: begin
        if (!nrfd_in) begin
          sh_next = GDI_SH_DRIV;
        end
      end
      GDI_SH_DRIV: begin
        if (!ndac_in) begin
          sh_next = GDI_SH_DONE;
        end
      end
      GDI_SH_DONE: begin
        sh_next = GDI_SH_IDLE;
      end
      default: sh_next = GDI_SH_IDLE;
    endcase
    if (!talk_active) begin
      sh_next = GDI_SH_IDLE;
    end
  end

  // Addressing, remote, lockout, poll state and one-cycle events
  always_comb begin
    st_next    = st_reg;
    clr_next   = 1'b0;
    abort_next = 1'b0;
    trig_next  = 1'b0;
    // Dropping remote enable returns the instrument to local at once
    st_next.remote = st_reg.remote && ren;
    if (!ren) begin
      st_next.lockout = 1'b0;
    end
    if (cmd_take) begin
      if (is_mta) begin
        st_next.talker   = 1'b1;
        st_next.listener = 1'b0;
      end
      if (is_ota || is_unt) begin
        st_next.talker = 1'b0;
      end
      if (is_mla) begin
        st_next.listener = 1'b1;
        st_next.talker   = 1'b0;
        st_next.remote   = ren;
      end
      if (is_unl) begin
        st_next.listener = 1'b0;
      end
      if (is_cmd) begin
        case (cmd)
          GDI_CMD_LLO: st_next.lockout = ren;
          GDI_CMD_GTL: begin
            if (st_reg.listener) begin
              st_next.remote  = 1'b0;
              st_next.lockout = 1'b0;
            end
          end
          GDI_CMD_GET: trig_next = st_reg.listener;
          GDI_CMD_SPE: st_next.spoll = 1'b1;
          GDI_CMD_SPD: st_next.spoll = 1'b0;
          default: begin
          end
        endcase
      end
    end
    // Abort is raised only while an acquisition is really running
    if (dev_clear) begin
      clr_next   = 1'b1;
      abort_next = acq_busy;
    end
    // Interface clear comes last so it beats any address in the cycle
    if (ifc) begin
      st_next.talker   = 1'b0;
      st_next.listener = 1'b0;
      st_next.spoll    = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      ah_reg    <= GDI_AH_IDLE;
      sh_reg    <= GDI_SH_IDLE;
      st_reg    <= '0;
      out_reg   <= '0;
      clr_reg   <= 1'b0;
      abort_reg <= 1'b0;
      trig_reg  <= 1'b0;
    end else begin
      ah_reg    <= ah_next;
      sh_reg    <= sh_next;
      st_reg    <= st_next;
      out_reg   <= out_next;
      clr_reg   <= clr_next;
      abort_reg <= abort_next;
      trig_reg  <= trig_next;
    end
  end

  // Bus drivers; serial poll answers with the status byte, no parallel poll
  always_comb begin
    dio_oe   = talk_active && (sh_reg != GDI_SH_IDLE);
    dio_out  = out_reg.data;
    eoi_oe   = dio_oe;
    eoi_out  = out_reg.eoi;
    if (st_reg.spoll) begin
      dio_out = stb;
      dio_out[GDI_RQS_BIT] = service_req;
      eoi_out = 1'b0;
    end
    dav_oe   = dio_oe;
    dav_out  = (sh_reg == GDI_SH_DRIV);
    // Not-ready held while not waiting; open-drain style enables
    nrfd_out = (ah_reg != GDI_AH_WAIT) && (atn || st_reg.listener);
    nrfd_oe  = nrfd_out;
    ndac_out = (ah_reg != GDI_AH_HOLD) && (atn || st_reg.listener);
    ndac_oe  = ndac_out;
    // Service request is withheld while the status byte is polled
    srq_out  = service_req && !st_reg.spoll;
    srq_oe   = srq_out;
  end

  // Status and event outputs straight from flip-flops
  assign state        = st_reg;
  assign parser_reset = clr_reg;
  assign acq_abort    = abort_reg;
  assign trigger      = trig_reg;
endmodule
`default_nettype wire

// ### testbench/gdi_device_if_asserts.sv
// Port checker for the GPIB device interface
`timescale 1ns/100ps
`default_nettype none
module gdi_device_if_chk
  import gdi_pkg::*;
(
  // Clock, reset, bus inputs and acquisition busy
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       ifc,
  input wire logic       ren,
  input wire logic       atn,
  input wire logic       dav_in,
  input wire logic       acq_busy,
  // Device outputs
  input wire logic       ndac_out,
  input wire logic       dav_out,
  input wire logic       dio_oe,
  input wire logic       srq_out,
  input wire logic       rx_valid,
  input wire gdi_state_s state,
  input wire logic       parser_reset,
  input wire logic       acq_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Interface clear drops addressing and poll by the next cycle
  chk_ifc_unaddr: assert property (
    ifc |=> !state.talker && !state.listener && !state.spoll)
    else $error("addressing kept after interface clear");
  chk_ifc_stops: assert property (ifc [*2] |-> !dav_out)
    else $error("data valid driven during interface clear");
  chk_role_excl: assert property (
    !(state.talker && state.listener))
    else $error("talker and listener at once");
  chk_drive_talker: assert property (dio_oe |-> $past(state.talker))
    else $error("data lines driven while not talker");
  chk_rx_listener: assert property (
    $rose(rx_valid) |-> $past(state.listener))
    else $error("byte stored while not listener");
  chk_ack_dav: assert property (
    $fell(ndac_out) && (atn || state.listener) |-> $past(dav_in))
    else $error("accept without data valid");
  chk_clr_pulse: assert property (parser_reset |=> !parser_reset)
    else $error("parser reset longer than one cycle");
  chk_abort_busy: assert property (
    acq_abort |-> $past(acq_busy) && parser_reset)
    else $error("abort without running acquisition");
  chk_poll_srq: assert property (
    state.spoll && $past(state.spoll) |-> !srq_out)
    else $error("service request during serial poll");
  chk_ren_local: assert property (!ren |=> !state.lockout)
    else $error("lockout kept without remote enable");
  // Main scenarios reached
  cov_abort: cover property (acq_abort);
  cov_poll: cover property (state.spoll);
  cov_talk: cover property (dio_oe && dav_out);
endmodule
bind gdi_device_if gdi_device_if_chk u_chk (.clk(clk), .reset(reset),
  .ifc(ifc), .ren(ren), .atn(atn), .dav_in(dav_in), .acq_busy(acq_busy),
  .ndac_out(ndac_out), .dav_out(dav_out), .dio_oe(dio_oe),
  .srq_out(srq_out), .rx_valid(rx_valid), .state(state),
  .parser_reset(parser_reset), .acq_abort(acq_abort));
`default_nettype wire

// ### testbench/gdi_ctl_model.sv
// Bus controller model: sources bytes and accepts talker bytes
`timescale 1ns/100ps
`default_nettype none
module gdi_ctl_model (
  // Clock and wired bus levels
  input  wire logic       clk,
  input  wire logic       dav_w,
  input  wire logic       nrfd_w,
  input  wire logic       ndac_w,
  input  wire logic [7:0] dio_w,
  input  wire logic       eoi_w,
  // Lines driven by the controller (true = asserted)
  output var logic        atn,
  output var logic        ifc,
  output var logic        dav,
  output var logic        nrfd,
  output var logic        ndac,
  output var logic        eoi,
  output var logic [7:0]  dio
);
  // Rest as not ready, so a talker cannot run ahead of us
  initial begin
    atn = 0;
    ifc = 0;
    dav = 0;
    nrfd = 1;
    ndac = 1;
    eoi = 0;
    dio = 8'h5A;
  end
  // Bounded wait on one wired level, polled away from the edge
  task automatic wt(input int k);
    int n;
    n = 0;
    #1;
    while (!(k == 0 ? !nrfd_w : k == 1 ? nrfd_w : k == 2 ? !ndac_w :
             k == 3 ? dav_w : !dav_w)) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) gdi_device_if_tb.hang();
    end
  endtask
  // Source one byte; atn marks an interface message
  task automatic send(input logic a, input logic [7:0] b, input logic e);
    @(posedge clk);
    atn <= a;
    dio <= b;
    eoi <= e;
    nrfd <= 0;
    ndac <= 0;
    wt(0);
    @(posedge clk);
    dav <= 1;
    wt(1);
    wt(2);
    @(posedge clk);
    dav <= 0;
    dio <= ~b; // Released lines show a changed pattern
    eoi <= 0;
    nrfd <= 1;
    ndac <= 1;
  endtask
  // Accept one talker byte, holding acceptance back w cycles
  task automatic recv(output logic [7:0] b, output logic e, input int w);
    @(posedge clk);
    atn <= 0;
    nrfd <= 0;
    wt(3);
    b = dio_w;
    e = eoi_w;
    repeat (w) @(posedge clk);
    @(posedge clk);
    nrfd <= 1;
    ndac <= 0;
    wt(4);
    @(posedge clk);
    ndac <= 1;
  endtask
  // Interface clear held for two cycles
  task automatic clear_bus();
    @(posedge clk);
    ifc <= 1;
    repeat (2) @(posedge clk);
    ifc <= 0;
  endtask
endmodule
`default_nettype wire

// ### testbench/gdi_device_if_tb.sv
// Self-checking bench for the GPIB device interface
`timescale 1ns/100ps
`default_nettype none
module gdi_device_if_tb
  import gdi_pkg::*;
;
  localparam logic [4:0] MY = 5'h07;
  // Bench-driven inputs
  logic       clk = 0;
  logic       reset = 1;
  logic       ren = 0;
  logic       rx_ready = 0;
  logic       tx_valid = 0;
  logic       service_req = 0;
  logic       acq_busy = 0;
  logic [7:0] stb = 8'h81;
  logic [4:0] my_addr = MY;
  gdi_byte_s  tx_byte = '0;
  // Controller lines and device outputs
  logic       atn, ifc, dav_c, nrfd_c, ndac_c, eoi_c;
  logic [7:0] dio_c, dio_out;
  logic       dio_oe, eoi_out, eoi_oe, dav_out, dav_oe, nrfd_out, nrfd_oe;
  logic       ndac_out, ndac_oe, srq_out, srq_oe, rx_valid, tx_ready;
  logic       parser_reset, acq_abort, trigger;
  gdi_byte_s  rx_byte;
  gdi_state_s state;
  int         error_cnt = 0, check_count = 0, n_pr = 0, n_ab = 0, n_tr = 0;
  // Wired bus levels seen by both parties
  wire logic       dav_in = dav_c | (dav_oe & dav_out);
  wire logic       nrfd_in = nrfd_c | (nrfd_oe & nrfd_out);
  wire logic       ndac_in = ndac_c | (ndac_oe & ndac_out);
  wire logic       eoi_in = eoi_oe ? eoi_out : eoi_c;
  wire logic [7:0] dio_in = dio_oe ? dio_out : dio_c;

  always #2 clk = ~clk;

  gdi_device_if uut (.clk(clk), .reset(reset), .my_addr(my_addr),
    .atn(atn), .ifc(ifc), .ren(ren), .dio_in(dio_in), .dio_out(dio_out),
    .dio_oe(dio_oe), .eoi_in(eoi_in), .eoi_out(eoi_out), .eoi_oe(eoi_oe),
    .dav_in(dav_in), .dav_out(dav_out), .dav_oe(dav_oe),
    .nrfd_in(nrfd_in), .nrfd_out(nrfd_out), .nrfd_oe(nrfd_oe),
    .ndac_in(ndac_in), .ndac_out(ndac_out), .ndac_oe(ndac_oe),
    .srq_out(srq_out), .srq_oe(srq_oe), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .service_req(service_req),
    .stb(stb), .acq_busy(acq_busy), .state(state),
    .parser_reset(parser_reset), .acq_abort(acq_abort), .trigger(trigger));
  gdi_ctl_model ctl (.clk(clk), .dav_w(dav_in), .nrfd_w(nrfd_in),
    .ndac_w(ndac_in), .dio_w(dio_in), .eoi_w(eoi_in), .atn(atn), .ifc(ifc),
    .dav(dav_c), .nrfd(nrfd_c), .ndac(ndac_c), .eoi(eoi_c), .dio(dio_c));

  // Pulses are counted so a one-cycle event cannot slip past a check
  always @(posedge clk) begin
    if (parser_reset === 1'b1) n_pr++;
    if (acq_abort === 1'b1) n_ab++;
    if (trigger === 1'b1) n_tr++;
  end

  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // A bounded wait ran out
  task automatic hang();
    error_cnt++;
    report_and_stop();
  endtask

  task automatic cmd(input logic [7:0] b);
    ctl.send(1'b1, b, 1'b0);
    @(posedge clk); // Lets a one-cycle event reach its counter
  endtask

  // Addressing, command decode and a full receive buffer
  task automatic t_listen();
    int i;
    chk("unaddressed", state, 16'h0000);
    cmd({3'b001, MY + 5'h01});
    chk("foreign_mla", state.listener, 1'b0);
    cmd({3'b001, MY});
    chk("mla", {state.listener, state.remote}, 2'b11);
    cmd({1'b0, GDI_CMD_GET});
    chk("get", {rx_valid, n_tr[3:0]}, 5'h01);
    for (i = 0; i < 8; i++) ctl.send(1'b0, 8'hC0 | i[7:0], i == 7);
    repeat (4) @(posedge clk);
    chk("full_nrfd", nrfd_out, 1'b1);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      rx_ready <= 1;
      #1 chk("rx_byte", rx_byte, {i == 7, 8'hC0 | i[7:0]});
    end
    @(posedge clk);
    rx_ready <= 0;
    #1 chk("rx_empty", rx_valid, 1'b0);
    cmd(8'h3F);
    chk("unl", state.listener, 1'b0);
    cmd({3'b001, MY});
    cmd({3'b010, MY});
    chk("mta", {state.talker, state.listener}, 2'b10);
    $display("test listen done");
  endtask

  // Fill the send buffer, drain it slowly, then end the talker role
  task automatic t_talk();
    int k;
    int i;
    logic [7:0] b;
    logic e;
    @(posedge clk);
    tx_valid <= 1;
    tx_byte <= {1'b0, 8'h30};
    for (k = 0; k < 12; ) begin
      #1;
      if (tx_ready !== 1'b1) break;
      @(posedge clk);
      k++;
      tx_byte <= {k[0], 8'h30 | k[7:0]};
    end
    chk("tx_depth", k, GDI_FIFO_D);
    @(posedge clk);
    tx_valid <= 0;
    for (i = 0; i < k; i++) begin
      ctl.recv(b, e, i % 3);
      chk("tx_byte", {e, b}, {i[0], 8'h30 | i[7:0]});
    end
    for (i = 0; i < 4; i++) begin
      cmd({3'b010, MY});
      case (i)
        0: ctl.clear_bus();
        1: cmd({3'b010, MY + 5'h01});
        2: cmd({3'b001, MY});
        default: cmd(8'h5F);
      endcase
      chk("talk_end", state.talker, 1'b0);
    end
    $display("test talk done");
  endtask

  // Lockout, go-to-local, clears and serial poll
  task automatic t_misc();
    int i;
    logic [7:0] b;
    logic e;
    cmd({3'b001, MY}); // Addressed commands below need a listener
    cmd({1'b0, GDI_CMD_LLO});
    chk("llo", state.lockout, 1'b1);
    cmd({1'b0, GDI_CMD_GTL});
    chk("gtl", state.lockout, 1'b0);
    ctl.send(1'b0, 8'h11, 1'b0);
    acq_busy <= 1;
    cmd({1'b0, GDI_CMD_DCL});
    repeat (2) @(posedge clk);
    chk("dcl", {rx_valid, n_pr[3:0], n_ab[3:0]}, 9'h011);
    acq_busy <= 0;
    ctl.send(1'b0, 8'h22, 1'b0);
    cmd({1'b0, GDI_CMD_SDC});
    repeat (2) @(posedge clk);
    chk("sdc", {rx_valid, n_pr[3:0], n_ab[3:0]}, 9'h021);
    service_req <= 1;
    repeat (2) @(posedge clk);
    chk("srq", srq_out, 1'b1);
    for (i = 0; i < 2; i++) begin
      cmd({1'b0, GDI_CMD_SPE});
      chk("spe", {state.spoll, srq_out}, 2'b10);
      cmd({3'b010, MY});
      ctl.recv(b, e, i);
      chk("poll_byte", {e, b}, 9'h0C1);
      if (i == 0) cmd({1'b0, GDI_CMD_SPD});
      else ctl.clear_bus();
      chk("poll_end", state.spoll, 1'b0);
    end
    $display("test misc done");
  endtask

  // Reset, then the scenarios in order
  initial begin
    repeat (16) @(posedge clk);
    reset <= 0;
    ren <= 1;
    t_listen();
    t_talk();
    t_misc();
    report_and_stop();
  end
endmodule
`default_nettype wire
